// ==== design/pce_cfg.svh ====
// Constants of the port and comparator edge block: offsets, fields, reset values.
// Assumes inclusion by name from any design file that needs them.
`ifndef PCE_CFG_SVH
`define PCE_CFG_SVH

// The address decode uses byte address bits [7:4] as the region and [3:2] as the port.
`define PCE_REG_DATA       4'h0
`define PCE_REG_DIR        4'h1
`define PCE_REG_PULLUP     4'h2
`define PCE_REG_RMW_OR     4'h3
`define PCE_REG_RMW_AND    4'h4
`define PCE_REG_RMW_XOR    4'h5
`define PCE_REG_CTRL       4'h6
`define PCE_REG_IRQ        4'h7

// Offsets inside the CTRL and IRQ regions, taken from byte address bits [3:2].
`define PCE_CTRL_MODE      2'h0
`define PCE_CTRL_EDGE      2'h1
`define PCE_CTRL_TSRC      2'h2
`define PCE_IRQ_STATUS     2'h0
`define PCE_IRQ_MASK       2'h1

// Field positions.
`define PCE_MODE_ANALOG_BIT   1
`define PCE_EDGE_LSB          6
`define PCE_EDGE_MSB          7
`define PCE_TSRC_BIT          0
`define PCE_EVT_CMP_A         0
`define PCE_EVT_CMP_B         1

// The pin of the port that can feed the timer edge detector instead of the comparator.
`define PCE_ALT_PORT       2
`define PCE_ALT_BIT        0

// Reset values.
`define PCE_RST_PULLUP     1'b1
`define PCE_RST_DIR        1'b0
`define PCE_RST_OUT        1'b0

`endif

// ==== design/pce_pkg.sv ====
// Types of the port and comparator edge block.
// Assumes nothing of its surroundings.
`default_nettype none
package pce_pkg;

  // Edge choice for the comparator interrupts; the fourth code also means both edges.
  typedef enum logic [1:0] {
    PCE_EDGE_FALL = 2'b00,
    PCE_EDGE_RISE = 2'b01,
    PCE_EDGE_BOTH = 2'b10,
    PCE_EDGE_ALSO = 2'b11
  } pce_edge_e;

  typedef logic [1:0] pce_evt_t;

endpackage : pce_pkg

`default_nettype wire

// ==== design/pce_port_io.sv ====
// GPIO ports with pin read-back, read-modify-write, pull-up control and comparator edge irqs.
// Assumes pins and comparator results are asynchronous and an AHB-Lite master on clk.
//
// What this block does
// [RULE1] Every pin of the first three ports can be set as input or output.
// [RULE2] The pin input sampling path stays active even when the pin drives.
// [RULE3] A port read returns the synchronised pin level, never the output latch.
// [RULE4] OR, AND and XOR accesses read the pins, combine, then load the output latch.
// [RULE5] A pin's pull-up is switched off from the cycle after that pin becomes an output.
// [RULE6] Comparator results feed the two inputs only while the analog enable bit is set.
// [RULE7] Each comparator-fed input can interrupt on rising, falling or both edges.
// [RULE8] The timer edge detector takes the first comparator input or a third-port pin.
// [RULE9] All pin inputs are synchronised before edge detection, one request per edge.
`timescale 1ns/1ps
`default_nettype none
`include "pce_cfg.svh"

module pce_port_io #(
  parameter int unsigned NPORT = 3,
  parameter int unsigned PW    = 8
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic [NPORT-1:0][PW-1:0]  port_in,
  output logic [NPORT-1:0][PW-1:0]       port_out,
  output logic [NPORT-1:0][PW-1:0]       port_oe,
  output logic [NPORT-1:0][PW-1:0]       port_pullup_en,
  input  wire logic                      comparator_input_a,
  input  wire logic                      comparator_input_b,
  input  wire logic                      comparator_out_a,
  input  wire logic                      comparator_out_b,
  output logic                           comparator_enable,
  output logic                           timer_edge_in,
  output logic                           irq
);

  // The comparators themselves are analog, referenced to comparator_reference_a and
  // comparator_reference_b; only their digital results arrive here.

  if (NPORT < 3 || NPORT > 4 || PW < 2 || PW > 16)
  begin : g_bad_params
    $error("pce_port_io: NPORT must be 3..4 and PW 2..16");
  end

  // The slave never stalls: hreadyout is a flop held at one, so every transfer is zero-wait.
  // Bus state.
  logic                          dph_valid;
  logic                          dph_write;
  logic [7:0]                    dph_addr;
  logic [31:0]                   rd_word;
  logic                          next_dph_valid;
  logic                          next_dph_write;
  logic [7:0]                    next_dph_addr;
  logic [31:0]                   next_hrdata;
  logic                          accept;

  // Port and control state.
  logic [NPORT-1:0][PW-1:0]      pin_meta;
  logic [NPORT-1:0][PW-1:0]      pin_sync;
  logic [NPORT-1:0][PW-1:0]      pull_cfg;
  logic [NPORT-1:0][PW-1:0]      next_port_out;
  logic [NPORT-1:0][PW-1:0]      next_port_oe;
  logic [NPORT-1:0][PW-1:0]      next_pull_cfg;
  logic [NPORT-1:0][PW-1:0]      next_pullup;
  logic                          analog_en;
  logic                          next_analog_en;
  pce_pkg::pce_edge_e            edge_sel;
  pce_pkg::pce_edge_e            next_edge_sel;
  logic                          tsrc_alt;
  logic                          next_tsrc_alt;

  // Comparator path and interrupt state.
  logic [3:0]                    cmp_meta;
  logic [3:0]                    cmp_pins;
  logic [1:0]                    cmp_sync;
  logic [1:0]                    cmp_prev;
  pce_pkg::pce_evt_t             evt;
  pce_pkg::pce_evt_t             status;
  pce_pkg::pce_evt_t             mask;
  pce_pkg::pce_evt_t             next_status;
  pce_pkg::pce_evt_t             next_mask;
  logic                          next_irq;
  logic                          next_timer_edge_in;
  logic                          alt_edge_detect_pin;

  // The analog switch chooses between comparator results and the plain pin levels.
  // Both sets are synchronised before the choice, so no raw level reaches the edge logic.
  // Switching it can itself produce one edge, which software should mask around.
  assign cmp_sync = analog_en ? cmp_pins[3:2] : cmp_pins[1:0];  // [RULE6]

  assign alt_edge_detect_pin = pin_sync[`PCE_ALT_PORT][`PCE_ALT_BIT];
  assign accept              = hsel & hready & htrans[1];

  // Edge events on the synchronised comparator levels.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      unique case (edge_sel)
        pce_pkg::PCE_EDGE_FALL: evt[i] = cmp_prev[i] & ~cmp_sync[i];  // [RULE7]
        pce_pkg::PCE_EDGE_RISE: evt[i] = ~cmp_prev[i] & cmp_sync[i];  // [RULE7]
        pce_pkg::PCE_EDGE_BOTH,
        pce_pkg::PCE_EDGE_ALSO: evt[i] = cmp_prev[i] ^ cmp_sync[i];   // [RULE7] [RULE9]
      endcase
    end
  end

  // Read data for the address phase; port regions show pins, not latches.
  always_comb
  begin
    logic [3:0] region;
    logic [1:0] idx;
    region  = haddr[7:4];
    idx     = haddr[3:2];
    rd_word = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      unique case (region)
        `PCE_REG_DATA, `PCE_REG_RMW_OR, `PCE_REG_RMW_AND, `PCE_REG_RMW_XOR:
          if (32'(idx) < NPORT)
            rd_word = 32'(pin_sync[idx]);  // [RULE3]
        `PCE_REG_DIR:
          if (32'(idx) < NPORT)
            rd_word = 32'(port_oe[idx]);
        `PCE_REG_PULLUP:
          if (32'(idx) < NPORT)
            rd_word = 32'(pull_cfg[idx]);
        `PCE_REG_CTRL:
          unique case (idx)
            `PCE_CTRL_MODE: rd_word[`PCE_MODE_ANALOG_BIT] = analog_en;
            `PCE_CTRL_EDGE: rd_word[`PCE_EDGE_MSB:`PCE_EDGE_LSB] = edge_sel;
            `PCE_CTRL_TSRC: rd_word[`PCE_TSRC_BIT] = tsrc_alt;
            default:        rd_word = 32'h0000_0000;
          endcase
        `PCE_REG_IRQ:
          unique case (idx)
            `PCE_IRQ_STATUS: rd_word[1:0] = status;
            `PCE_IRQ_MASK:   rd_word[1:0] = mask;
            default:         rd_word = 32'h0000_0000;
          endcase
        default:
          rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Next values of all register state, written in the data phase.
  always_comb
  begin
    logic [3:0]    region;
    logic [1:0]    idx;
    logic [PW-1:0] opnd;
    logic          wr;
    pce_pkg::pce_evt_t w1c;
    region         = dph_addr[7:4];
    idx            = dph_addr[3:2];
    opnd           = hwdata[PW-1:0];
    wr             = dph_valid & dph_write;
    w1c            = '0;
    // Only the low page is mapped; a write above it must not alias onto a register.
    next_dph_valid = accept & (haddr[31:8] == 24'h00_0000);
    next_dph_write = hwrite;
    next_dph_addr  = haddr[7:0];
    next_hrdata    = (accept & ~hwrite) ? rd_word : 32'h0000_0000;
    next_port_out  = port_out;
    next_port_oe   = port_oe;
    next_pull_cfg  = pull_cfg;
    next_analog_en = analog_en;
    next_edge_sel  = edge_sel;
    next_tsrc_alt  = tsrc_alt;
    next_mask      = mask;
    if (wr && dph_addr[7] == 1'b0 && 32'(idx) < NPORT)
    begin
      unique case (region)
        `PCE_REG_DATA:    next_port_out[idx] = opnd;
        `PCE_REG_DIR:     next_port_oe[idx]  = opnd;                   // [RULE1]
        `PCE_REG_PULLUP:  next_pull_cfg[idx] = opnd;
        `PCE_REG_RMW_OR:  next_port_out[idx] = pin_sync[idx] | opnd;   // [RULE4]
        `PCE_REG_RMW_AND: next_port_out[idx] = pin_sync[idx] & opnd;   // [RULE4]
        `PCE_REG_RMW_XOR: next_port_out[idx] = pin_sync[idx] ^ opnd;   // [RULE4]
        default:          next_port_out = port_out;
      endcase
    end
    if (wr && region == `PCE_REG_CTRL)
    begin
      unique case (idx)
        `PCE_CTRL_MODE: next_analog_en = hwdata[`PCE_MODE_ANALOG_BIT];  // [RULE6]
        `PCE_CTRL_EDGE: next_edge_sel  =
                          pce_pkg::pce_edge_e'(hwdata[`PCE_EDGE_MSB:`PCE_EDGE_LSB]);  // [RULE7]
        `PCE_CTRL_TSRC: next_tsrc_alt  = hwdata[`PCE_TSRC_BIT];         // [RULE8]
        default:        next_tsrc_alt  = tsrc_alt;
      endcase
    end
    if (wr && region == `PCE_REG_IRQ)
    begin
      unique case (idx)
        `PCE_IRQ_STATUS: w1c       = hwdata[1:0];
        `PCE_IRQ_MASK:   next_mask = hwdata[1:0];
        default:         w1c       = '0;
      endcase
    end
    // A new edge wins over a clear written in the same cycle.
    // Losing the set here would hide an edge that software never saw.
    next_status        = (status & ~w1c) | evt;
    next_irq           = |(status & mask);
    next_timer_edge_in = tsrc_alt ? alt_edge_detect_pin : cmp_sync[0];  // [RULE8]
  end

  // Pull-ups follow configuration but drop out on every driven pin.
  for (genvar p = 0; p < NPORT; p++)
  begin : g_pull
    assign next_pullup[p] = pull_cfg[p] & ~port_oe[p];  // [RULE5]
  end

  // Pin and comparator synchronisers run on every pin regardless of direction.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      cmp_meta <= 4'h0;
      cmp_pins <= 4'h0;
      cmp_prev <= 2'h0;
    end
    else if (ce)
    begin
      pin_meta <= port_in;    // [RULE2] [RULE9]
      pin_sync <= pin_meta;   // [RULE2] [RULE9]
      cmp_meta <= {comparator_out_b, comparator_out_a,
                   comparator_input_b, comparator_input_a};  // [RULE9]
      cmp_pins <= cmp_meta;   // [RULE9]
      cmp_prev <= cmp_sync;
    end
  end

  // Register state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_valid         <= 1'b0;
      dph_write         <= 1'b0;
      dph_addr          <= 8'h00;
      hrdata            <= 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      port_out          <= {NPORT*PW{`PCE_RST_OUT}};
      port_oe           <= {NPORT*PW{`PCE_RST_DIR}};
      pull_cfg          <= {NPORT*PW{`PCE_RST_PULLUP}};
      port_pullup_en    <= {NPORT*PW{`PCE_RST_PULLUP}};
      analog_en         <= 1'b0;
      comparator_enable <= 1'b0;
      edge_sel          <= pce_pkg::PCE_EDGE_FALL;
      tsrc_alt          <= 1'b0;
      status            <= '0;
      mask              <= '0;
      irq               <= 1'b0;
      timer_edge_in     <= 1'b0;
    end
    else if (ce)
    begin
      dph_valid         <= next_dph_valid;
      dph_write         <= next_dph_write;
      dph_addr          <= next_dph_addr;
      hrdata            <= next_hrdata;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      port_out          <= next_port_out;
      port_oe           <= next_port_oe;
      pull_cfg          <= next_pull_cfg;
      port_pullup_en    <= next_pullup;
      analog_en         <= next_analog_en;
      comparator_enable <= next_analog_en;   // [RULE6]
      edge_sel          <= next_edge_sel;
      tsrc_alt          <= next_tsrc_alt;
      status            <= next_status;      // [RULE7]
      mask              <= next_mask;
      irq               <= next_irq;
      timer_edge_in     <= next_timer_edge_in;
    end
  end

  // The bus only carries whole words; hsize is accepted but not checked.
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[1:0], htrans[0], hwdata[31:PW]};

endmodule : pce_port_io

`default_nettype wire

// ==== tb/pce_checker.sv ====
// Checker of the port block: bus reads, latch, direction, pull-up and pin read-back.
// Assumes a bind to pce_port_io and ce held high while the bus is used.
`timescale 1ns/1ps
`default_nettype none
module pce_checker #(
  parameter int unsigned NPORT = 3,
  parameter int unsigned PW    = 8
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     ce,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [31:0]              hwdata,
  input wire logic                     hreadyout,
  input wire logic [31:0]              hrdata,
  input wire logic [NPORT-1:0][PW-1:0] port_in,
  input wire logic [NPORT-1:0][PW-1:0] port_out,
  input wire logic [NPORT-1:0][PW-1:0] port_oe,
  input wire logic [NPORT-1:0][PW-1:0] port_pullup_en,
  input wire logic                     comparator_enable
);
  logic                     pv;
  logic                     pw;
  logic [7:0]               pa;
  logic [1:0]               st;
  logic [NPORT-1:0][PW-1:0] pq;
  // Pins count as settled after three quiet edges, which covers the two-flop input lag.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pv <= 1'b0;
      st <= 2'h0;
    end
    else
    begin
      pv <= hsel && hreadyout && htrans[1] && ce && haddr[31:8] == 24'h00_0000;
      st <= (port_in != pq) ? 2'h0 : (st == 2'h3) ? st : st + 2'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    pw <= hwrite;
    pa <= haddr[7:0];
    pq <= port_in;
  end
  sequence s_wr(logic [3:0] r, logic q);
    pv && pw && pa[7:4] == r && pa[3:2] < NPORT && q;
  endsequence
  sequence s_rd_pins;
    pv && !pw && pa[7:4] == 4'h0 && pa[3:2] < NPORT && st == 2'h3;
  endsequence
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_dir_write: assert property (
    s_wr(4'h1, 1'b1) |=> port_oe[$past(pa[3:2])] == $past(hwdata[PW-1:0]))
    else $error("direction write lost");
  a_oe_hold: assert property (
    $changed(port_oe) |-> $past(pv && pw && pa[7:4] == 4'h1))
    else $error("direction changed without write");
  a_latch_write: assert property (
    s_wr(4'h0, 1'b1) |=> port_out[$past(pa[3:2])] == $past(hwdata[PW-1:0]))
    else $error("latch write lost");
  a_rmw_xor: assert property (
    s_wr(4'h5, st == 2'h3) |=> port_out[$past(pa[3:2])] ==
      ($past(hwdata[PW-1:0]) ^ $past(pq[pa[3:2]])))
    else $error("xor not based on pins");
  a_read_pins: assert property (
    s_rd_pins |-> hrdata == 32'(pq[pa[3:2]]))
    else $error("read not from pins");
  a_rdata_idle: assert property (
    !(pv && !pw) |-> hrdata == 32'h0000_0000)
    else $error("read data outside read");
  a_pullup_off: assert property (
    $stable(port_oe) |-> (port_pullup_en & port_oe) == '0)
    else $error("pull-up on an output");
  a_analog_en: assert property (
    s_wr(4'h6, pa[3:2] == 2'h0) |=> comparator_enable == $past(hwdata[1]))
    else $error("analog enable not taken");
endmodule : pce_checker
bind pce_port_io pce_checker #(.NPORT(NPORT), .PW(PW)) u_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
  .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
  .port_pullup_en(port_pullup_en), .comparator_enable(comparator_enable)
);
`default_nettype wire

// ==== tb/pce_pins.sv ====
// Model of the circuits on the port pins: external drivers facing the port.
// Assumes every pin that the design does not drive is driven from outside.
`timescale 1ns/1ps
`default_nettype none
module pce_pins #(
  parameter int unsigned NPORT = 3,
  parameter int unsigned PW    = 8
) (
  input wire logic [NPORT-1:0][PW-1:0] port_out,
  input wire logic [NPORT-1:0][PW-1:0] port_oe,
  input wire logic [NPORT-1:0][PW-1:0] ext_val,
  output logic [NPORT-1:0][PW-1:0]     port_in
);
  // A driving pin shows its own latch, so output pins read back what they drive.
  always_comb
    port_in = (port_oe & port_out) | (~port_oe & ext_val);
endmodule : pce_pins
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench of the port block: pins, read-modify-write, edges, interrupt and timer source.
// Assumes pce_pins on the pins and pce_checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned NP = 3;
  localparam int unsigned W  = 8;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      ce = 1'b1;
  logic                      hsel = 1'b0;
  logic                      hwrite = 1'b0;
  logic [1:0]                htrans = 2'h0;
  logic [31:0]               haddr = '0;
  logic [31:0]               hwdata = '0;
  logic                      ca = 1'b0;
  logic                      cb = 1'b0;
  logic                      oa = 1'b0;
  logic                      ob = 1'b0;
  logic [NP-1:0][W-1:0]      ev = '0;
  wire logic                 hreadyout, hresp, cen, ten, irq;
  wire logic [31:0]          hrdata;
  wire logic [NP-1:0][W-1:0] port_in, port_out, port_oe, pu;
  logic [31:0]               r;
  logic [W-1:0]              d, v, e, m, cur;
  logic [1:0]                es;
  logic                      lv;
  int                        num_errors = 0;
  int                        n_compared = 0;
  int                        cyc = 0;
  always #12.5 clk = ~clk;
  pce_port_io #(.NPORT(NP), .PW(W)) u_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .port_pullup_en(pu),
    .comparator_input_a(ca), .comparator_input_b(cb), .comparator_out_a(oa),
    .comparator_out_b(ob), .comparator_enable(cen), .timer_edge_in(ten), .irq(irq));
  pce_pins #(.NPORT(NP), .PW(W)) u_pins (
    .port_out(port_out), .port_oe(port_oe), .ext_val(ev), .port_in(port_in));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // The master waits on hready at every phase instead of assuming zero wait states.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(a);
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", '0, 32'(hresp));
  endtask : xfer
  task automatic drive(input logic a, input logic l);
    ca <= l ^ a;
    cb <= l ^ a;
    oa <= l ~^ a;
    ob <= l ~^ a;
  endtask : drive
  function automatic logic [W-1:0] rmw(input int op, input logic [W-1:0] p, x);
    return op == 3 ? (p | x) : op == 4 ? (p & x) : (p ^ x);
  endfunction : rmw
  function automatic logic hit(input logic [1:0] c, input logic rise);
    return rise ? c != 2'h0 : c != 2'h1;
  endfunction : hit
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(32'he8e2_2ccf));
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    chk("pullup", 32'h00ff_ffff, 32'(pu));
    chk("idle", '0, 32'({port_oe, cen, ten, irq}));
    for (int p = 0; p < NP; p++)
    begin
      d = W'($urandom);
      v = W'($urandom);
      e = W'($urandom);
      m = W'($urandom);
      ev[p] <= e;
      xfer(1'b1, 8'(16 + 4 * p), 32'(d));
      xfer(1'b1, 8'(4 * p), 32'(v));
      xfer(1'b1, 8'(32 + 4 * p), 32'(m));
      tick(4);
      cur = (d & v) | (~d & e);
      chk("dir", 32'(d), 32'(port_oe[p]));
      chk("pullup", 32'(m & ~d), 32'(pu[p]));
      xfer(1'b0, 8'(4 * p), '0);
      chk("pins", 32'(cur), r);
      xfer(1'b0, 8'(16 + 4 * p), '0);
      chk("dir_rd", 32'(d), r);
      xfer(1'b0, 8'(32 + 4 * p), '0);
      chk("pull_rd", 32'(m), r);
      for (int op = 3; op < 6; op++)
      begin
        m = W'($urandom);
        xfer(1'b1, 8'(16 * op + 4 * p), 32'(m));
        v = rmw(op, cur, m);
        tick(1);
        chk("latch", 32'(v), 32'(port_out[p]));
        cur = (d & v) | (~d & e);
        tick(4);
      end
    end
    xfer(1'b0, 8'h0c, '0);
    chk("unmapped", '0, r);
    ce <= 1'b0;
    xfer(1'b1, 8'h08, 32'(~v));
    ce <= 1'b1;
    tick(2);
    chk("frozen", 32'(v), 32'(port_out[2]));
    lv = 1'b1;
    for (int an = 0; an < 2; an++)
    begin
      xfer(1'b1, 8'h60, 32'(2 * an));
      lv = ~lv;
      drive(an[0], lv);
      tick(8);
      chk("analog", 32'(an), 32'(cen));
      xfer(1'b0, 8'h60, '0);
      chk("mode_rd", 32'(2 * an), r);
      xfer(1'b1, 8'h70, 32'h3);
      for (int c = 0; c < 4; c++)
      begin
        m = W'($urandom % 4);
        xfer(1'b1, 8'h64, 32'(c << 6));
        xfer(1'b1, 8'h74, 32'(m));
        xfer(1'b0, 8'h64, '0);
        chk("edge_rd", 32'(c << 6), r);
        xfer(1'b0, 8'h74, '0);
        chk("mask_rd", 32'(m), r);
        repeat (2)
        begin
          lv = ~lv;
          drive(an[0], lv);
          tick(8);
          es = hit(2'(c), lv) ? 2'h3 : 2'h0;
          xfer(1'b0, 8'h70, '0);
          chk("status", 32'(es), r);
          chk("irq", 32'((es & m[1:0]) != 2'h0), 32'(irq));
          xfer(1'b1, 8'h70, 32'h3);
          tick(4);
          xfer(1'b0, 8'h70, '0);
          chk("cleared", '0, r);
        end
      end
    end
    xfer(1'b1, 8'h60, '0);
    xfer(1'b1, 8'h18, '0);
    for (int k = 0; k < 4; k++)
    begin
      ca <= k[0];
      oa <= k[0];
      ev[2] <= {W{~k[0]}};
      xfer(1'b1, 8'h68, 32'(k[1]));
      tick(6);
      chk("timer", 32'(k[0] ^ k[1]), 32'(ten));
      xfer(1'b0, 8'h68, '0);
      chk("tsrc_rd", 32'(k[1]), r);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
